// ### cbt_top.sv
// Register slave, bit timing engine and time stamp control of the CAN block
`timescale 1ns/1ns
module cbt_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [cbt_pkg::CBT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cbt_pkg::CBT_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [cbt_pkg::CBT_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic can_rx,
  input wire logic rx_frame_ok,
  input wire logic tx_frame_ok,
  output logic sample_point_strobe,
  output logic bit_level,
  output logic bit_level_valid,
  output logic bit_start,
  output logic [15:0] mailbox_stamp_value,
  output logic mailbox_stamp_write,
  output logic config_mode,
  output logic sleep_mode,
  output logic global_irq_flag
);
  import cbt_pkg::*;

  // Lane merge for the two low byte lanes that carry register data
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  // Register state
  logic [7:0] baud_prescale;
  logic [9:0] seg_cfg;
  logic [3:0] stamp_prescale;
  logic config_change_request;
  logic sleep_request;
  logic stamp_overflow_flag;
  logic soft_rst;
  logic ccr_prev;
  logic smr_prev;
  logic [15:0] stamp_counter;
  logic [15:0] stamp_hold;
  logic stamp_ovf;
  logic rx_level;
  logic rx_major;
  logic rx_prev;

  // Bus decode
  wire [CBT_ADDR_W-1:0] word_addr = {avs_address[CBT_ADDR_W-1:2], 2'b00};
  wire wr_take = avs_write && !avs_waitrequest;
  wire rd_take = avs_read && avs_waitrequest;
  wire hit_prescale = (word_addr == OFS_PRESCALE_CFG);
  wire hit_segment = (word_addr == OFS_SEGMENT_CFG);
  wire hit_stamp = (word_addr == OFS_STAMP_VALUE);
  wire hit_stamp_pre = (word_addr == OFS_STAMP_PRESCALE);
  wire hit_master = (word_addr == OFS_MASTER_CTRL);
  wire hit_irq = (word_addr == OFS_IRQ_FLAGS);
  wire hit_status = (word_addr == OFS_GLOBAL_STATUS);
  wire hit_hold = (word_addr == OFS_STAMP_HOLD);
  wire [15:0] master_wr = merge16({8'h00, config_change_request, sleep_request, 6'h00},
                                  avs_writedata, avs_byteenable);
  wire rst_all = sys_rst || soft_rst;

  // Writes to the configuration pair pass only while access is requested
  wire cfg_open = config_change_request;
  wire wr_prescale = wr_take && hit_prescale && cfg_open;
  wire wr_segment = wr_take && hit_segment && cfg_open;
  wire wr_stamp = wr_take && hit_stamp && !sleep_request;
  wire wr_stamp_pre = wr_take && hit_stamp_pre;
  wire wr_master = wr_take && hit_master;
  wire wr_sres = wr_master && avs_byteenable[0] && avs_writedata[MC_SRES_BIT];
  wire wr_stamp_counter_clear = wr_master && avs_byteenable[0] && avs_writedata[MC_STAMP_COUNTER_CLEAR_BIT];
  wire clr_tso = wr_take && hit_irq && avs_byteenable[0] && avs_writedata[GIF_TSO_BIT];

  wire [15:0] next_prescale = merge16({8'h00, baud_prescale}, avs_writedata, avs_byteenable);
  wire [15:0] next_segment = merge16({6'h00, seg_cfg}, avs_writedata, avs_byteenable);
  wire [15:0] next_stamp_pre = merge16({12'h000, stamp_prescale}, avs_writedata,
                                       avs_byteenable);
  wire [15:0] next_stamp_val = merge16(stamp_counter, avs_writedata, avs_byteenable);

  // Read mux; unused upper bits and unmapped words read zero
  wire [15:0] rd_status = {8'h00, config_change_request, sleep_request, 2'b00,
                           stamp_overflow_flag, 3'b000};
  wire [15:0] rd_master = {8'h00, config_change_request, sleep_request, 6'h00};
  wire [15:0] rd_irq = {15'h0000, stamp_overflow_flag};
  wire [15:0] next_readdata =
    hit_prescale ? {8'h00, baud_prescale} :
    hit_segment ? {6'h00, seg_cfg} :
    hit_stamp ? stamp_counter :
    hit_stamp_pre ? {12'h000, stamp_prescale} :
    hit_master ? rd_master :
    hit_irq ? rd_irq :
    hit_status ? rd_status :
    hit_hold ? stamp_hold : 16'h0000;

  // Slave answers with waitrequest low one cycle after the request appears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_take) begin
        avs_readdata <= {16'h0000, next_readdata};
      end
    end
  end

  // Soft reset comes as a pulse one cycle after the write is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_sres;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      baud_prescale <= PRESCALE_RST;
      seg_cfg <= SEGMENT_RST;
      stamp_prescale <= STAMP_PRE_RST;
      config_change_request <= CCR_RST;
      sleep_request <= SMR_RST;
    end else begin
      if (wr_prescale) begin
        baud_prescale <= next_prescale[7:0];
      end
      if (wr_segment) begin
        seg_cfg <= next_segment[9:0];
      end
      if (wr_stamp_pre) begin
        stamp_prescale <= next_stamp_pre[3:0];
      end
      if (wr_master) begin
        config_change_request <= master_wr[MC_CCR_BIT];
        sleep_request <= master_wr[MC_SMR_BIT];
      end
    end
  end

  // Overflow sets win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst_all) begin
      stamp_overflow_flag <= 1'b0;
    end else if (stamp_ovf) begin
      stamp_overflow_flag <= 1'b1;
    end else if (clr_tso) begin
      stamp_overflow_flag <= 1'b0;
    end
  end

  // Mode entry detection for clearing the stamp logic
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ccr_prev <= CCR_RST;
      smr_prev <= SMR_RST;
    end else begin
      ccr_prev <= config_change_request;
      smr_prev <= sleep_request;
    end
  end

  wire enter_cfg = config_change_request && !ccr_prev;
  wire enter_sleep = sleep_request && !smr_prev;
  wire stamp_clear = rst_all || enter_cfg || enter_sleep || wr_stamp_pre || wr_stamp_counter_clear;
  wire bt_run = !config_change_request && !sleep_request;

  // Bit timing: quantum prescaler and segment sequencer
  cbt_state_e state;
  cbt_state_e next_state;
  logic [7:0] tq_cnt;
  logic [4:0] q_cnt;
  logic [4:0] next_q_cnt;
  logic [5:0] seg1_end;
  logic [5:0] next_seg1_end;
  logic [3:0] seg2_end;
  logic [3:0] next_seg2_end;
  logic resynced;
  logic next_resynced;
  logic restart_tq;
  logic bit_tick;
  logic sp_now;
  logic [1:0] ipt_cnt;

  wire tq_tick = (tq_cnt == baud_prescale);
  wire [5:0] seg1_len = {2'b00, seg_cfg[SEG_ONE_LSB +: 4]} + 6'h01;
  wire [3:0] seg2_len = {1'b0, seg_cfg[SEG_TWO_LSB +: 3]} + 4'h1;
  wire [2:0] jump_len = {1'b0, seg_cfg[JUMP_LSB +: 2]} + 3'h1;
  wire fall = rx_prev && !rx_level;
  wire [5:0] late_err = {1'b0, q_cnt} + 6'h01;
  wire [5:0] late_fix = (late_err > {3'b000, jump_len}) ? {3'b000, jump_len} : late_err;
  wire [3:0] early_left = seg2_end - q_cnt[3:0];
  wire triple_on = seg_cfg[TRIPLE_BIT] && (baud_prescale >= TRIPLE_MIN_PRESCALE);
  wire sample_val = triple_on ? rx_major : rx_level;

  always_comb begin
    next_state = state;
    next_q_cnt = q_cnt;
    next_seg1_end = seg1_end;
    next_seg2_end = seg2_end;
    next_resynced = resynced;
    restart_tq = 1'b0;
    bit_tick = 1'b0;
    sp_now = 1'b0;
    if (!bt_run) begin
      next_state = BT_SYNC;
      next_q_cnt = 5'h00;
      restart_tq = 1'b1;
    end else begin
      case (state)
        BT_SYNC: begin
          if (tq_tick) begin
            next_state = BT_SEG1;
            next_q_cnt = 5'h00;
            next_seg1_end = seg1_len;
            next_seg2_end = seg2_len;
            next_resynced = 1'b0;
          end
        end
        BT_SEG1: begin
          // Late edge lengthens segment one by the error, at most the jump
          if (fall && !resynced) begin
            next_seg1_end = seg1_len + late_fix;
            next_resynced = 1'b1;
          end
          if (tq_tick && ({1'b0, q_cnt} + 6'h01 >= seg1_end)) begin
            next_state = BT_SEG2;
            next_q_cnt = 5'h00;
            sp_now = 1'b1;
          end else if (tq_tick) begin
            next_q_cnt = q_cnt + 5'h01;
          end
        end
        BT_SEG2: begin
          // Early edge shortens segment two; a short remainder restarts the bit
          if (fall && !resynced && (early_left <= {1'b0, jump_len})) begin
            next_state = BT_SEG1;
            next_q_cnt = 5'h00;
            next_seg1_end = seg1_len;
            next_seg2_end = seg2_len;
            restart_tq = 1'b1;
            bit_tick = 1'b1;
          end else if (tq_tick && ({1'b0, q_cnt[3:0]} + 5'h01 >= {1'b0, seg2_end})) begin
            next_state = BT_SYNC;
            next_q_cnt = 5'h00;
            bit_tick = 1'b1;
          end else begin
            if (fall && !resynced) begin
              next_seg2_end = seg2_end - {1'b0, jump_len};
              next_resynced = 1'b1;
            end
            if (tq_tick) begin
              next_q_cnt = q_cnt + 5'h01;
            end
          end
        end
        default: begin
          next_state = BT_SYNC;
          next_q_cnt = 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      state <= BT_SYNC;
      q_cnt <= 5'h00;
      seg1_end <= 6'h01;
      seg2_end <= 4'h1;
      resynced <= 1'b0;
      tq_cnt <= 8'h00;
      rx_prev <= 1'b1;
    end else begin
      state <= next_state;
      q_cnt <= next_q_cnt;
      seg1_end <= next_seg1_end;
      seg2_end <= next_seg2_end;
      resynced <= next_resynced;
      tq_cnt <= (restart_tq || tq_tick) ? 8'h00 : tq_cnt + 8'h01;
      rx_prev <= rx_level;
    end
  end

  // Sample point, bit level and the processing interval after it
  always_ff @(posedge clk) begin
    if (rst_all) begin
      sample_point_strobe <= 1'b0;
      bit_level <= 1'b1;
      bit_level_valid <= 1'b0;
      bit_start <= 1'b0;
      ipt_cnt <= 2'h0;
    end else begin
      sample_point_strobe <= sp_now;
      bit_start <= bit_tick;
      if (sp_now) begin
        bit_level <= sample_val;
        ipt_cnt <= IPT_CYCLES;
      end else if (ipt_cnt != 2'h0) begin
        ipt_cnt <= ipt_cnt - 2'h1;
      end
      bit_level_valid <= (ipt_cnt == 2'h1) && !sp_now;
    end
  end

  // Frame success pulses come from the protocol engine at the end of frame
  wire stamp_capture = rx_frame_ok || tx_frame_ok;

  cbt_rx_sample u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .can_rx(can_rx),
    .rx_level(rx_level),
    .rx_major(rx_major)
  );

  cbt_stamp #(
    .CNT_W(16)
  ) u_stamp (
    .clk(clk),
    .clear(stamp_clear),
    .run(bt_run),
    .bit_tick(bit_tick),
    .prescale(stamp_prescale),
    .load(wr_stamp),
    .load_value(next_stamp_val),
    .capture(stamp_capture),
    .count(stamp_counter),
    .hold(stamp_hold),
    .overflow(stamp_ovf)
  );

  // Mailbox write follows capture by one cycle and carries the counter value from the capture cycle
  always_ff @(posedge clk) begin
    if (rst_all) begin
      mailbox_stamp_write <= 1'b0;
      mailbox_stamp_value <= 16'h0000;
      config_mode <= CCR_RST;
      sleep_mode <= SMR_RST;
      global_irq_flag <= 1'b0;
    end else begin
      mailbox_stamp_write <= stamp_capture && !stamp_clear;
      mailbox_stamp_value <= (stamp_capture && !stamp_clear) ? stamp_counter
                                                               : stamp_hold;
      config_mode <= config_change_request;
      sleep_mode <= sleep_request;
      global_irq_flag <= stamp_overflow_flag || stamp_ovf;
    end
  end
endmodule : cbt_top

// ### cbt_pkg.sv
// Constants and types shared by the CAN bit timing and time stamp block
// Functional notes
// - One quantum lasts prescale plus one clocks
// - Jump width select gives one to four quanta
// - Bit is sync, segment one, segment two
// - Three clock processing interval after sample point
// - Resynchronise on falling edges, limited by jump
// - Triple sampling takes majority of three clocks
// - Prescale below four forces single sampling
// - Config registers reset zero, upper bits zero
// - Sixteen bit counter stamps stored or sent frames
// - Counter runs on bit clock, stops configuring/sleeping
// - Host reads and writes counter in config/normal
// - Overflow sets both flags; write one clears
// - Four bit stamp prescale multiplies bit period
// - Hold register captures counter on frame success
// - Success defined at end of frame bits
// - Counter and hold clear on reset/mode entry/prescale write
// - Config writes only while change request set
// - Stamp clear bit clears counter, reads zero
package cbt_pkg;
  localparam int CBT_ADDR_W = 8;
  localparam int CBT_DATA_W = 32;
  localparam logic [7:0] OFS_PRESCALE_CFG = 8'h00;
  localparam logic [7:0] OFS_SEGMENT_CFG = 8'h04;
  localparam logic [7:0] OFS_STAMP_VALUE = 8'h08;
  localparam logic [7:0] OFS_STAMP_PRESCALE = 8'h0C;
  localparam logic [7:0] OFS_MASTER_CTRL = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] OFS_GLOBAL_STATUS = 8'h18;
  localparam logic [7:0] OFS_STAMP_HOLD = 8'h1C;
  localparam int MC_CCR_BIT = 7;
  localparam int MC_SMR_BIT = 6;
  localparam int MC_STAMP_COUNTER_CLEAR_BIT = 1;
  localparam int MC_SRES_BIT = 0;
  localparam int GIF_TSO_BIT = 0;
  localparam int GSR_CCE_BIT = 7;
  localparam int GSR_SMA_BIT = 6;
  localparam int GSR_TSO_BIT = 3;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [9:0] SEGMENT_RST = 10'h000;
  localparam logic [3:0] STAMP_PRE_RST = 4'h0;
  localparam logic CCR_RST = 1'b1;
  localparam logic SMR_RST = 1'b0;
  localparam int SEG_ONE_LSB = 0;
  localparam int SEG_TWO_LSB = 4;
  localparam int TRIPLE_BIT = 7;
  localparam int JUMP_LSB = 8;
  localparam logic [1:0] IPT_CYCLES = 2'h3;
  localparam logic [7:0] TRIPLE_MIN_PRESCALE = 8'h04;
  typedef enum logic [1:0] {BT_SYNC, BT_SEG1, BT_SEG2} cbt_state_e;
endpackage : cbt_pkg

// ### cbt_rx_sample.sv
// Bus input synchroniser with three clock sample history
`timescale 1ns/1ns
module cbt_rx_sample (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic can_rx,
  output logic rx_level,
  output logic rx_major
);
  logic meta;
  logic hist1;
  logic hist2;

  // Recessive is the idle level, so the chain resets high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b1;
      rx_level <= 1'b1;
      hist1 <= 1'b1;
      hist2 <= 1'b1;
    end else begin
      meta <= can_rx;
      rx_level <= meta;
      hist1 <= rx_level;
      hist2 <= hist1;
    end
  end

  // Majority of this sample and the two one and two clocks before
  assign rx_major = (rx_level & hist1) | (rx_level & hist2) | (hist1 & hist2);
endmodule : cbt_rx_sample

// ### cbt_stamp.sv
// Free running time stamp counter with prescaler and hold register
`timescale 1ns/1ns
module cbt_stamp #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic clear,
  input wire logic run,
  input wire logic bit_tick,
  input wire logic [3:0] prescale,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic capture,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] hold,
  output logic overflow
);
  logic [3:0] pre_cnt;
  wire pre_done = (pre_cnt == prescale);
  wire advance = run && bit_tick && pre_done;
  wire at_max = (count == {CNT_W{1'b1}});

  always_ff @(posedge clk) begin
    if (clear) begin
      count <= '0;
      hold <= '0;
      pre_cnt <= 4'h0;
      overflow <= 1'b0;
    end else begin
      overflow <= advance && at_max;
      if (run && bit_tick) begin
        pre_cnt <= pre_done ? 4'h0 : pre_cnt + 4'h1;
      end
      if (load) begin
        count <= load_value;
      end else if (advance) begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (capture) begin
        hold <= count;
      end
    end
  end
endmodule : cbt_stamp

// ### cbt_top_assertions.sv
// Concurrent checks on the ports of the CAN bit timing and time stamp block
`timescale 1ns/1ns
module cbt_top_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [cbt_pkg::CBT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cbt_pkg::CBT_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [cbt_pkg::CBT_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_frame_ok,
  input wire logic tx_frame_ok,
  input wire logic sample_point_strobe,
  input wire logic bit_level,
  input wire logic bit_level_valid,
  input wire logic bit_start,
  input wire logic mailbox_stamp_write,
  input wire logic config_mode,
  input wire logic sleep_mode,
  input wire logic global_irq_flag
);
  import cbt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd_ans;
  assign rd_ans = avs_read && !avs_waitrequest;
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Soft reset may abort the interval and forces configuration mode, so only a running engine is judged
  chk_valid_delay: assert property ($rose(sample_point_strobe) ##1
    (!config_mode && !sleep_mode)[*3] |-> bit_level_valid)
    else $error("bit level not valid three clocks after sample point");
  chk_valid_cause: assert property (bit_level_valid |-> $past(sample_point_strobe, 3))
    else $error("bit level valid without sample point three clocks before");
  // Mode entry and soft reset clear the stamp the cycle after a write, refusing capture
  chk_stamp_pulse: assert property ((rx_frame_ok || tx_frame_ok) && !avs_write
    && !$past(avs_write) |=> mailbox_stamp_write)
    else $error("frame success not followed by stamp write");
  chk_stamp_cause: assert property (mailbox_stamp_write
    |-> $past(rx_frame_ok) || $past(tx_frame_ok))
    else $error("stamp write without frame success");
  // The pin is registered from the flag, so the clear shows two edges later
  chk_irq_clear: assert property (avs_write && !avs_waitrequest
    && avs_address[7:2] == OFS_IRQ_FLAGS[7:2] && avs_writedata[GIF_TSO_BIT]
    && avs_byteenable[0] |-> ##2 !global_irq_flag)
    else $error("overflow flag not cleared by write of one");
  chk_mc_reads: assert property (rd_ans && avs_address[7:2] == OFS_MASTER_CTRL[7:2]
    |-> avs_readdata[MC_STAMP_COUNTER_CLEAR_BIT] == 1'b0 && avs_readdata[MC_SRES_BIT] == 1'b0)
    else $error("write only control bits read nonzero");
  chk_cfg_upper: assert property (rd_ans && avs_address[7:2] == OFS_SEGMENT_CFG[7:2]
    |-> avs_readdata[31:10] == 22'h0)
    else $error("segment register upper bits nonzero");
  chk_cfg_stops: assert property (config_mode && $past(config_mode, 2)
    |-> !bit_start && !sample_point_strobe)
    else $error("bit timing running in configuration mode");
  cov_overflow: cover property ($rose(global_irq_flag));
  cov_stamp: cover property (mailbox_stamp_write);
  cov_dominant: cover property (bit_level_valid && !bit_level);
endmodule : cbt_top_assertions

bind cbt_top cbt_top_assertions cbt_top_assertions_inst (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_frame_ok(rx_frame_ok), .tx_frame_ok(tx_frame_ok),
  .sample_point_strobe(sample_point_strobe), .bit_level(bit_level),
  .bit_level_valid(bit_level_valid), .bit_start(bit_start),
  .mailbox_stamp_write(mailbox_stamp_write), .config_mode(config_mode),
  .sleep_mode(sleep_mode), .global_irq_flag(global_irq_flag)
);

// ### cbt_bus_node.sv
// Model of another node on the CAN bus driving the receive line
`timescale 1ns/1ns
module cbt_bus_node #(
  parameter int LOW_LEN = 400
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  output logic can_rx
);
  int cnt;
  // Dominant for LOW_LEN clocks, then released so the pull-up gives recessive
  always_ff @(posedge clk) begin
    if (sys_rst) cnt <= 0;
    else if (go) cnt <= LOW_LEN;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign can_rx = (cnt == 0);
endmodule : cbt_bus_node

// ### cbt_top_tb_top.sv
// Self-checking testbench for the CAN bit timing and time stamp block
`timescale 1ns/1ns
module cbt_top_tb_top;
  import cbt_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic rx_frame_ok = 1'b0;
  logic tx_frame_ok = 1'b0;
  logic node_go = 1'b0;
  logic [31:0] avs_readdata, rd_val, ref_val;
  logic [15:0] mailbox_stamp_value;
  logic avs_waitrequest, can_rx, sample_point_strobe, bit_level, bit_level_valid, bit_start;
  logic mailbox_stamp_write, config_mode, sleep_mode, global_irq_flag;
  int err_total = 0;
  int compares = 0;
  int n;
  always #2 clk = ~clk;
  cbt_top cbt_top_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .can_rx(can_rx), .rx_frame_ok(rx_frame_ok), .tx_frame_ok(tx_frame_ok),
    .sample_point_strobe(sample_point_strobe), .bit_level(bit_level),
    .bit_level_valid(bit_level_valid), .bit_start(bit_start),
    .mailbox_stamp_value(mailbox_stamp_value), .mailbox_stamp_write(mailbox_stamp_write),
    .config_mode(config_mode), .sleep_mode(sleep_mode), .global_irq_flag(global_irq_flag));
  cbt_bus_node cbt_bus_node_inst (.clk(clk), .sys_rst(sys_rst), .go(node_go), .can_rx(can_rx));
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task hang;
    chk(32'h1, 32'h0);
    end_of_test();
  endtask : hang
  // Holds the request until the edge that samples waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) hang();
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask : rdchk
  // Counts settled clock edges until the chosen pulse shows
  task wev(input int sel);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((sel == 0 ? bit_start : sel == 1 ? sample_point_strobe : bit_level_valid)
      !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask : wev
  task t_regs;
    rdchk(OFS_PRESCALE_CFG, 32'h0);
    rdchk(OFS_SEGMENT_CFG, 32'h0);
    rdchk(OFS_MASTER_CTRL, 32'h80);
    chk(config_mode, 1'b1);
    rdchk(OFS_GLOBAL_STATUS, 32'h80);
    rdchk(8'h20, 32'h0);
    wr(OFS_PRESCALE_CFG, 32'hFFFF);
    rdchk(OFS_PRESCALE_CFG, 32'hFF);
    wr(OFS_MASTER_CTRL, 32'h0);
    wr(OFS_PRESCALE_CFG, 32'h12);
    rdchk(OFS_PRESCALE_CFG, 32'hFF);
    wr(OFS_MASTER_CTRL, 32'h1);
    rdchk(OFS_PRESCALE_CFG, 32'h0);
    rdchk(OFS_MASTER_CTRL, 32'h80);
    $display("register test done");
  endtask : t_regs
  task t_timing(input logic [7:0] p, input logic [9:0] seg);
    wr(OFS_MASTER_CTRL, 32'h80);
    wr(OFS_PRESCALE_CFG, {24'h0, p});
    wr(OFS_SEGMENT_CFG, {22'h0, seg});
    rdchk(OFS_SEGMENT_CFG, {22'h0, seg});
    wr(OFS_MASTER_CTRL, 32'h0);
    wev(0);
    wev(1);
    chk(n, (p + 1) * (seg[3:0] + 2));
    wev(2);
    chk(n, 3);
    wev(0);
    chk(n + 3, (p + 1) * (seg[6:4] + 1));
    $display("timing test done");
  endtask : t_timing
  // Falling edge six quanta into the bit, so the phase error exceeds any jump
  task t_resync(input logic [1:0] js);
    wr(OFS_MASTER_CTRL, 32'h80);
    wr(OFS_PRESCALE_CFG, 32'h7);
    wr(OFS_SEGMENT_CFG, {22'h0, js, 8'h3F});
    wr(OFS_MASTER_CTRL, 32'h0);
    wev(0);
    repeat (45) @(posedge clk);
    node_go <= 1'b1;
    @(posedge clk);
    node_go <= 1'b0;
    wev(0);
    chk(n + 46, 8 * (22 + js));
    wev(1);
    chk(bit_level, 1'b0);
    $display("resync test done");
  endtask : t_resync
  task t_stamp;
    wr(OFS_MASTER_CTRL, 32'h80);
    wr(OFS_STAMP_VALUE, 32'h1234);
    rdchk(OFS_STAMP_VALUE, 32'h1234);
    wr(OFS_MASTER_CTRL, 32'h0);
    rdchk(OFS_STAMP_VALUE, 32'h1234);
    wr(OFS_STAMP_PRESCALE, 32'h2);
    rdchk(OFS_STAMP_VALUE, 32'h0);
    wev(0);
    bus(1'b0, OFS_STAMP_VALUE, 32'h0);
    ref_val = rd_val;
    repeat (9) wev(0);
    rdchk(OFS_STAMP_VALUE, ref_val + 3);
    wr(OFS_STAMP_PRESCALE, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wev(0);
      bus(1'b0, OFS_STAMP_VALUE, 32'h0);
      ref_val = rd_val;
      @(posedge clk);
      rx_frame_ok <= (i == 0);
      tx_frame_ok <= (i == 1);
      @(posedge clk);
      rx_frame_ok <= 1'b0;
      tx_frame_ok <= 1'b0;
      #1;
      chk(mailbox_stamp_write, 1'b1);
      chk(mailbox_stamp_value, ref_val);
      rdchk(OFS_STAMP_HOLD, ref_val);
    end
    wev(0);
    wr(OFS_STAMP_VALUE, 32'hFFFF);
    wev(0);
    rdchk(OFS_STAMP_VALUE, 32'h0);
    rdchk(OFS_IRQ_FLAGS, 32'h1);
    rdchk(OFS_GLOBAL_STATUS, 32'h8);
    chk(global_irq_flag, 1'b1);
    wr(OFS_IRQ_FLAGS, 32'h1);
    rdchk(OFS_IRQ_FLAGS, 32'h0);
    rdchk(OFS_GLOBAL_STATUS, 32'h0);
    chk(global_irq_flag, 1'b0);
    wev(0);
    wr(OFS_MASTER_CTRL, 32'h2);
    rdchk(OFS_STAMP_VALUE, 32'h0);
    rdchk(OFS_MASTER_CTRL, 32'h0);
    wev(0);
    @(posedge clk);
    rx_frame_ok <= 1'b1;
    @(posedge clk);
    rx_frame_ok <= 1'b0;
    wr(OFS_MASTER_CTRL, 32'h40);
    rdchk(OFS_GLOBAL_STATUS, 32'h40);
    chk(sleep_mode, 1'b1);
    rdchk(OFS_STAMP_HOLD, 32'h0);
    wr(OFS_STAMP_VALUE, 32'h55);
    repeat (400) @(posedge clk);
    rdchk(OFS_STAMP_VALUE, 32'h0);
    $display("stamp test done");
  endtask : t_stamp
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_timing(8'h00, 10'h034);
    t_timing(8'h04, 10'h0A5);
    for (int j = 0; j < 4; j++) t_resync(j[1:0]);
    t_stamp();
    end_of_test();
  end
endmodule : cbt_top_tb_top
